/* hdl/adc_fmt_pkg.sv */
package adc_fmt_pkg;

  // register addresses of the serial configuration port
  localparam logic [6:0] DRIVER_MODE_ADDR = 7'h03;
  localparam logic [6:0] DATA_FORMAT_ADDR = 7'h04;
  localparam logic [7:0] DRIVER_MODE_RESET = 8'h00;
  localparam logic [7:0] DATA_FORMAT_RESET = 8'h00;

  // output_driver_mode fields
  localparam int DRV_DISABLE_BIT = 0;
  localparam int DRV_TERM_BIT = 1;
  localparam int DRV_CURRENT_LSB = 2;
  localparam logic [7:0] DRV_USED_MASK = 8'h1f;

  // output_data_format fields
  localparam int FMT_TWOS_BIT = 0;
  localparam int FMT_RANDOMIZE_BIT = 1;
  localparam int FMT_PAT_EN_BIT = 2;
  localparam int FMT_ALT_POL_BIT = 4;
  localparam int FMT_PAT_LSB = 5;
  localparam logic [7:0] FMT_USED_MASK = 8'hf7;

  // serial frame: read flag, 7 address bits, 8 data bits
  localparam logic [4:0] SPI_HDR_LAST = 5'h07;
  localparam logic [4:0] SPI_FRAME_LAST = 5'h0f;
  localparam logic [4:0] SPI_FRAME_BITS = 5'h10;

  // drive current codes
  localparam logic [2:0] CUR_3P5 = 3'h0;
  localparam logic [2:0] CUR_4P0 = 3'h1;
  localparam logic [2:0] CUR_4P5 = 3'h2;
  localparam logic [2:0] CUR_UNUSED = 3'h3;
  localparam logic [2:0] CUR_3P0 = 3'h4;
  localparam logic [2:0] CUR_2P5 = 3'h5;
  localparam logic [2:0] CUR_2P1 = 3'h6;
  localparam logic [2:0] CUR_1P75 = 3'h7;

  // test pattern codes and words (overflow, data 11..0)
  localparam logic [2:0] PAT_ZERO = 3'h0;
  localparam logic [2:0] PAT_ONE = 3'h1;
  localparam logic [2:0] PAT_TOGGLE = 3'h2;
  localparam logic [2:0] PAT_CHECKER = 3'h4;
  localparam logic [12:0] WORD_ZERO = 13'h0000;
  localparam logic [12:0] WORD_ONE = 13'h1fff;
  localparam logic [12:0] WORD_CHECKER = 13'h0aaa;
  localparam logic [11:0] ODD_BITS = 12'haaa;

  typedef struct packed {
    logic overflow;
    logic [11:0] data;
  } sample_t;

  typedef struct packed {
    logic rd;
    logic [6:0] addr;
    logic [7:0] data;
  } spi_word_t;

endpackage : adc_fmt_pkg

/* hdl/spi_config_port.sv */
`timescale 1ns/100ps
module spi_config_port (
  input wire logic i_spi_sck,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sdi,
  output logic o_spi_sdo,
  output logic o_spi_sdo_oe_n,
  input wire logic [7:0] i_driver_mode,
  input wire logic [7:0] i_data_format,
  output adc_fmt_pkg::spi_word_t o_word,
  output logic o_word_done
);
  import adc_fmt_pkg::*;

  typedef struct packed {
    logic [4:0] cnt;
    logic [14:0] shift;
    logic [7:0] sdo_shift;
    logic rd_active;
  } frame_t;

  typedef struct packed {
    logic [7:0] drv_meta;
    logic [7:0] drv_sync;
    logic [7:0] fmt_meta;
    logic [7:0] fmt_sync;
    logic done;
    spi_word_t word;
  } held_t;

  frame_t f;
  frame_t next_f;
  held_t h;
  held_t next_h;
  logic [15:0] bits;

  assign bits = {f.shift, i_spi_sdi};

  always_comb begin
    next_f = f;
    next_h = h;
    next_h.drv_meta = i_driver_mode;
    next_h.drv_sync = h.drv_meta;
    next_h.fmt_meta = i_data_format;
    next_h.fmt_sync = h.fmt_meta;
    next_f.shift = bits[14:0];
    if (f.cnt != SPI_FRAME_BITS) begin
      next_f.cnt = f.cnt + 5'h01;
    end
    // old write stays valid until the next frame starts
    if (f.cnt == 5'h00) begin
      next_h.done = 1'b0;
    end
    if (f.rd_active) begin
      next_f.sdo_shift = {f.sdo_shift[6:0], 1'b0};
    end
    if (f.cnt == SPI_HDR_LAST && bits[7]) begin
      next_f.rd_active = 1'b1;
      if (bits[6:0] == DRIVER_MODE_ADDR) begin
        next_f.sdo_shift = h.drv_sync;
      end else if (bits[6:0] == DATA_FORMAT_ADDR) begin
        next_f.sdo_shift = h.fmt_sync;
      end else begin
        next_f.sdo_shift = 8'h00;
      end
    end
    if (f.cnt == SPI_FRAME_LAST && !bits[15]) begin
      next_h.done = 1'b1;
      next_h.word = bits;
    end
  end

  // frame state cleared by the select itself, since sck stops between frames
  always_ff @(posedge i_spi_sck or posedge i_spi_cs_n) begin
    if (i_spi_cs_n) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  always_ff @(posedge i_spi_sck) begin
    h <= next_h;
  end

  assign o_spi_sdo = f.sdo_shift[7];
  assign o_spi_sdo_oe_n = i_spi_cs_n | ~f.rd_active;
  assign o_word = h.word;
  assign o_word_done = h.done;

endmodule : spi_config_port

/* hdl/sample_formatter.sv */
`timescale 1ns/100ps
module sample_formatter (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input adc_fmt_pkg::sample_t i_sample,
  input wire logic [7:0] i_format,
  output adc_fmt_pkg::sample_t o_sample
);
  import adc_fmt_pkg::*;

  typedef struct packed {
    logic phase;
    sample_t out;
  } state_t;

  state_t s;
  state_t next_s;
  logic [2:0] code;

  assign code = i_format[FMT_PAT_LSB +: 3];

  always_comb begin
    next_s = s;
    next_s.phase = ~s.phase;
    next_s.out = i_sample;
    if (i_format[FMT_TWOS_BIT]) begin
      next_s.out.data[11] = ~i_sample.data[11];
    end
    // randomizer keys bits 11..1 by bit 0
    if (i_format[FMT_RANDOMIZE_BIT]) begin
      next_s.out.data[11:1] = next_s.out.data[11:1] ^ {11{next_s.out.data[0]}};
    end
    if (i_format[FMT_ALT_POL_BIT]) begin
      next_s.out.data = next_s.out.data ^ ODD_BITS;
    end
    if (i_format[FMT_PAT_EN_BIT]) begin
      unique case (code)
        PAT_ZERO: next_s.out = WORD_ZERO;
        PAT_ONE: next_s.out = WORD_ONE;
        PAT_TOGGLE: next_s.out = s.phase ? WORD_ONE : WORD_ZERO;
        PAT_CHECKER: next_s.out = s.phase ? ~WORD_CHECKER : WORD_CHECKER;
        // unlisted codes pass conversion data
        default: next_s.out = next_s.out;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_sample = s.out;

endmodule : sample_formatter

/* hdl/adc_output_format_control.sv */
`timescale 1ns/100ps
// What this block does
// - drive current code picks 3.5/4.0/4.5/3.0/2.5/2.1/1.75 mA; 011 unused.
// - termination enable switches in internal termination and doubles drive current.
// - output disable low drives DDR lanes; high tristates all seven lanes (SDO keeps its own enable).
// - pattern 000 forces all outputs low, 001 forces all high.
// - pattern 010 toggles overflow and data between all zeros and ones.
// - pattern 100 alternates checkerboard word and its complement each sample.
// - pattern code acts only while pattern enable is set.
// - alternate polarity bit enables or disables alternate bit polarity mode.
// - randomizer bit enables or disables the data randomizer.
// - number format bit: 0 offset binary, 1 two's complement.
// - unused upper three bits of driver mode read back as zero.
module adc_output_format_control (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input adc_fmt_pkg::sample_t i_sample,
  input wire logic i_spi_sck,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sdi,
  output logic o_spi_sdo,
  output logic o_spi_sdo_oe_n,
  output logic [6:0] o_lane_rise,
  output logic [6:0] o_lane_fall,
  output logic o_lane_oe_n,
  output logic o_term_enable,
  output logic [2:0] o_drive_current_code,
  output logic [13:0] o_drive_current_ua
);
  import adc_fmt_pkg::*;

  typedef struct packed {
    logic [7:0] driver_mode;
    logic [7:0] data_format;
    logic cs_meta;
    logic cs_sync;
    logic cs_last;
    logic [6:0] rise;
    logic [6:0] fall;
    logic oe_n;
    logic term;
    logic [2:0] code;
    logic [13:0] current_ua;
  } state_t;

  state_t s;
  state_t next_s;
  spi_word_t word;
  logic word_done;
  logic frame_end;
  sample_t formatted;
  logic [6:0] next_rise;
  logic [6:0] next_fall;
  logic [13:0] base_ua;

  spi_config_port u_spi (
    .i_spi_sck(i_spi_sck),
    .i_spi_cs_n(i_spi_cs_n),
    .i_spi_sdi(i_spi_sdi),
    .o_spi_sdo(o_spi_sdo),
    .o_spi_sdo_oe_n(o_spi_sdo_oe_n),
    .i_driver_mode(s.driver_mode),
    .i_data_format(s.data_format),
    .o_word(word),
    .o_word_done(word_done)
  );

  sample_formatter u_fmt (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_sample(i_sample),
    .i_format(s.data_format),
    .o_sample(formatted)
  );

  // word and done are still once the select has risen and synchronised
  assign frame_end = s.cs_sync & ~s.cs_last;

  // even data bits in the rising half, odd in the falling half
  genvar k;
  generate
    for (k = 0; k < 6; k++) begin : g_lane
      assign next_rise[k] = formatted.data[2 * k];
      assign next_fall[k] = formatted.data[2 * k + 1];
    end
  endgenerate
  assign next_rise[6] = formatted.overflow;
  assign next_fall[6] = formatted.overflow;

  always_comb begin
    unique case (s.driver_mode[DRV_CURRENT_LSB +: 3])
      CUR_3P5: base_ua = 14'h0dac;
      CUR_4P0: base_ua = 14'h0fa0;
      CUR_4P5: base_ua = 14'h1194;
      CUR_3P0: base_ua = 14'h0bb8;
      CUR_2P5: base_ua = 14'h09c4;
      CUR_2P1: base_ua = 14'h0834;
      CUR_1P75: base_ua = 14'h06d6;
      // never stored, see register write below
      default: base_ua = 14'h0dac;
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.cs_meta = i_spi_cs_n;
    next_s.cs_sync = s.cs_meta;
    next_s.cs_last = s.cs_sync;
    if (frame_end && word_done) begin
      if (word.addr == DRIVER_MODE_ADDR) begin
        next_s.driver_mode = word.data & DRV_USED_MASK;
        if (word.data[DRV_CURRENT_LSB +: 3] == CUR_UNUSED) begin
          next_s.driver_mode[DRV_CURRENT_LSB +: 3] =
            s.driver_mode[DRV_CURRENT_LSB +: 3];
        end
      end else if (word.addr == DATA_FORMAT_ADDR) begin
        next_s.data_format = word.data & FMT_USED_MASK;
      end
    end
    next_s.rise = next_rise;
    next_s.fall = next_fall;
    next_s.oe_n = s.driver_mode[DRV_DISABLE_BIT];
    next_s.term = s.driver_mode[DRV_TERM_BIT];
    next_s.code = s.driver_mode[DRV_CURRENT_LSB +: 3];
    next_s.current_ua = s.driver_mode[DRV_TERM_BIT] ? {base_ua[12:0], 1'b0} : base_ua;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s <= '0;
      s.driver_mode <= DRIVER_MODE_RESET;
      s.data_format <= DATA_FORMAT_RESET;
      s.cs_meta <= 1'b1;
      s.cs_sync <= 1'b1;
      s.cs_last <= 1'b1;
      s.oe_n <= 1'b1;
      s.current_ua <= 14'h0dac;
    end else begin
      s <= next_s;
    end
  end

  assign o_lane_rise = s.rise;
  assign o_lane_fall = s.fall;
  assign o_lane_oe_n = s.oe_n;
  assign o_term_enable = s.term;
  assign o_drive_current_code = s.code;
  assign o_drive_current_ua = s.current_ua;

endmodule : adc_output_format_control

/* verif/adc_output_format_control_checker.sv */
`timescale 1ns/100ps
module adc_output_format_control_checker (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_spi_cs_n,
  input wire logic o_spi_sdo_oe_n,
  input wire logic [6:0] o_lane_rise,
  input wire logic [6:0] o_lane_fall,
  input wire logic o_lane_oe_n,
  input wire logic o_term_enable,
  input wire logic [2:0] o_drive_current_code,
  input wire logic [13:0] o_drive_current_ua
);
  import adc_fmt_pkg::*;
  logic [3:0] quiet;
  logic [13:0] base;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // sys cycles since reset or since the frame select went high, saturating
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !i_spi_cs_n) quiet <= 4'h0;
    else if (quiet != 4'hf) quiet <= quiet + 4'h1;
  end
  always_comb begin
    case (o_drive_current_code)
      3'h0: base = 14'h0dac;
      3'h1: base = 14'h0fa0;
      3'h2: base = 14'h1194;
      3'h4: base = 14'h0bb8;
      3'h5: base = 14'h09c4;
      3'h6: base = 14'h0834;
      default: base = 14'h06d6;
    endcase
  end
  reset_state_a: assert property (disable iff (1'b0)
    i_rst |=> o_lane_oe_n && o_drive_current_ua == 14'h0dac) else $error("reset state");
  current_table_a: assert property (
    o_drive_current_ua == (o_term_enable ? {base[12:0], 1'b0} : base)) else $error("current");
  code_unused_a: assert property (
    o_drive_current_code != 3'h3) else $error("unused code");
  term_double_a: assert property (
    $rose(o_term_enable) && $stable(o_drive_current_code) |->
    o_drive_current_ua == {$past(o_drive_current_ua[12:0]), 1'b0}) else $error("no doubling");
  config_quiet_a: assert property (
    !$stable({o_lane_oe_n, o_term_enable, o_drive_current_code}) |-> quiet inside {[1:8]})
    else $error("config changed outside a write");
  overflow_pair_a: assert property (
    o_lane_rise[6] == o_lane_fall[6]) else $error("overflow split");
  sdo_idle_a: assert property (
    i_spi_cs_n |-> o_spi_sdo_oe_n) else $error("sdo driven while idle");
  oe_hold_a: assert property (
    $fell(i_rst) |-> o_lane_oe_n ##1 (o_lane_oe_n == DRIVER_MODE_RESET[DRV_DISABLE_BIT]))
    else $error("lane enable wrong after reset");
  cover property ($rose(o_term_enable));
  cover property ($fell(o_lane_oe_n));
  cover property (!o_spi_sdo_oe_n);
endmodule : adc_output_format_control_checker

bind adc_output_format_control adc_output_format_control_checker chk (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_spi_cs_n(i_spi_cs_n),
  .o_spi_sdo_oe_n(o_spi_sdo_oe_n), .o_lane_rise(o_lane_rise), .o_lane_fall(o_lane_fall),
  .o_lane_oe_n(o_lane_oe_n), .o_term_enable(o_term_enable),
  .o_drive_current_code(o_drive_current_code), .o_drive_current_ua(o_drive_current_ua));

/* verif/lane_capture_model.sv */
`timescale 1ns/100ps
module lane_capture_model (
  input wire logic i_sys_clk,
  input wire logic [6:0] i_lane_rise,
  input wire logic [6:0] i_lane_fall,
  input wire logic i_lane_oe_n,
  output adc_fmt_pkg::sample_t o_word,
  output logic o_valid
);
  import adc_fmt_pkg::*;
  // floating lanes give no usable word
  always_ff @(posedge i_sys_clk) begin
    o_valid <= !i_lane_oe_n;
    o_word.overflow <= i_lane_oe_n ? ~o_word.overflow : i_lane_rise[6];
    for (int k = 0; k < 6; k++) begin
      o_word.data[2*k] <= i_lane_oe_n ? ~o_word.data[2*k] : i_lane_rise[k];
      o_word.data[2*k+1] <= i_lane_oe_n ? ~o_word.data[2*k+1] : i_lane_fall[k];
    end
  end
endmodule : lane_capture_model

/* verif/test_adc_output_format_control.sv */
`timescale 1ns/100ps
module test_adc_output_format_control;
  import adc_fmt_pkg::*;
  logic i_sys_clk = 0;
  logic i_rst = 1;
  logic sck = 0;
  logic cs_n = 1'b0;
  logic sdi = 0;
  sample_t smp = '0;
  sample_t word;
  logic sdo, sdo_oe_n, lane_oe_n, term, valid;
  logic [6:0] rise, fall;
  logic [2:0] code;
  logic [13:0] ua;
  logic [7:0] rd;
  int error_cnt = 0;
  int checked = 0;
  adc_output_format_control uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_sample(smp),
    .i_spi_sck(sck), .i_spi_cs_n(cs_n), .i_spi_sdi(sdi), .o_spi_sdo(sdo),
    .o_spi_sdo_oe_n(sdo_oe_n), .o_lane_rise(rise), .o_lane_fall(fall),
    .o_lane_oe_n(lane_oe_n), .o_term_enable(term), .o_drive_current_code(code),
    .o_drive_current_ua(ua));
  lane_capture_model far (.i_sys_clk(i_sys_clk), .i_lane_rise(rise), .i_lane_fall(fall),
    .i_lane_oe_n(lane_oe_n), .o_word(word), .o_valid(valid));
  initial begin
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  task automatic check(input logic [13:0] got, input logic [13:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one serial frame; read data lands in rd
  task automatic xfer(input logic r, input logic [6:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {r, a, d};
    @(posedge i_sys_clk) cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      #31.5 sdi <= f[i];
      #31 sck <= 1'b1;
      #62.5 if (i > 0 && i < 9) rd[i-1] = sdo;
      sck <= 1'b0;
    end
    #31 @(posedge i_sys_clk) cs_n <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
    #1;
  endtask : xfer
  task automatic t_reset;
    check(ua, 14'h0dac);
    check(lane_oe_n, DRIVER_MODE_RESET[DRV_DISABLE_BIT]);
    xfer(1'b1, DRIVER_MODE_ADDR, 8'h00);
    check(rd, DRIVER_MODE_RESET);
    xfer(1'b1, DATA_FORMAT_ADDR, 8'h00);
    check(rd, DATA_FORMAT_RESET);
    xfer(1'b1, 7'h10, 8'h00);
    check(rd, 8'h00);
    $display("reset test done");
  endtask : t_reset
  task automatic t_driver;
    logic [13:0] tbl [8] = '{14'h0dac, 14'h0fa0, 14'h1194, 14'h0000,
      14'h0bb8, 14'h09c4, 14'h0834, 14'h06d6};
    logic [7:0] m;
    for (int n = 0; n < 16; n++) begin
      m = {3'h7, n[3:1], n[0], n[2] ^ n[0]};
      if (n[3:1] != 3'h3) begin
        xfer(1'b0, DRIVER_MODE_ADDR, m);
        check(code, m[4:2]);
        check(ua, m[1] ? tbl[m[4:2]] << 1 : tbl[m[4:2]]);
        check(term, m[1]);
        check(lane_oe_n, m[0]);
        xfer(1'b1, DRIVER_MODE_ADDR, 8'h00);
        check(rd, m & DRV_USED_MASK);
      end
    end
    xfer(1'b0, DRIVER_MODE_ADDR, {3'h0, CUR_UNUSED, 2'h0});
    check(code, CUR_1P75);
    check(ua, 14'h06d6);
    $display("driver mode test done");
  endtask : t_driver
  task automatic t_pattern;
    logic [2:0] c;
    sample_t w;
    for (int p = 0; p < 4; p++) begin
      c = (p == 3) ? PAT_CHECKER : 3'(p);
      xfer(1'b0, DATA_FORMAT_ADDR, {c, 5'h04});
      repeat (4) @(posedge i_sys_clk);
      #1 w = word;
      @(posedge i_sys_clk) #1;
      check(valid, 1'b1);
      check(w, p == 0 ? WORD_ZERO : p == 1 ? WORD_ONE : p == 2 ? (w[0] ? WORD_ONE : WORD_ZERO)
        : (w[0] ? sample_t'(~WORD_CHECKER) : WORD_CHECKER));
      check(word, p < 2 ? w : sample_t'(~w));
    end
    $display("pattern test done");
  endtask : t_pattern
  function automatic sample_t fmt_exp(input sample_t s, input logic [2:0] k);
    sample_t e;
    e = s;
    if (k[0]) e.data[11] = ~e.data[11];
    if (k[1]) e.data[11:1] = e.data[11:1] ^ {11{e.data[0]}};
    if (k[2]) e.data = e.data ^ ODD_BITS;
    return e;
  endfunction : fmt_exp
  task automatic t_format;
    logic [7:0] f;
    @(posedge i_sys_clk) smp <= 13'h1c35;
    for (int k = 0; k < 8; k++) begin
      // pattern code set but enable clear
      f = {3'h1, k[2], 2'h0, k[1], k[0]};
      xfer(1'b0, DATA_FORMAT_ADDR, f);
      repeat (4) @(posedge i_sys_clk);
      #1 check(word, fmt_exp(13'h1c35, k[2:0]));
      xfer(1'b1, DATA_FORMAT_ADDR, 8'h00);
      check(rd, f);
    end
    $display("format test done");
  endtask : t_format
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  initial begin
    #300000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    // a real rising edge on the select clears the link-side frame state
    cs_n <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
    #1;
    t_reset();
    t_driver();
    t_pattern();
    t_format();
    tally_and_finish();
  end
endmodule : test_adc_output_format_control
